//--- sdram_core.sv
// command decode, bank tracking, bursts, power-down and clock suspend of an sdram
// assumes the controller drives pins on clk; the cell array takes writes through
// a two-entry buffer and returns read data in the same cycle as a read request
`timescale 1ns/1ps
`default_nettype none
module sdram_core
  import sdram_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command and data pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] addr,
  input wire logic bank_select_high,
  input wire logic bank_select_low,
  input wire logic [NBYTE-1:0] dqm,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [NBYTE-1:0] dq_oe_n,
  // mode settings
  input wire logic write_single_mode_bit,
  input wire logic [2:0] burst_len_code,
  input wire logic cas_lat3,
  // write stream to the cell array
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output logic [BANK_W-1:0] arr_wr_bank,
  output logic [ROW_W-1:0] arr_wr_row,
  output logic [COL_W-1:0] arr_wr_col,
  output logic [NBYTE-1:0] arr_wr_mask,
  output logic [DQ_W-1:0] arr_wr_data,
  output logic wr_buf_ready,
  // read requests to the cell array
  output logic arr_rd_valid,
  output logic [BANK_W-1:0] arr_rd_bank,
  output logic [ROW_W-1:0] arr_rd_row,
  output logic [COL_W-1:0] arr_rd_col,
  input wire logic [DQ_W-1:0] arr_rdata,
  // status
  output logic power_down,
  output logic active_power_down,
  output logic clock_suspended,
  output logic [NBANK-1:0] bank_open
);
  typedef struct packed {
    logic pd;
    logic apd;
    logic sus;
    logic cke_q;
    logic act;
    logic wr;
    logic full;
    logic ap;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] wrap;
    logic [LEFT_W-1:0] left;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][ROW_W-1:0] row;
    logic [NBANK-1:0][APC_W-1:0] apc;
    logic rq;
    logic [BANK_W-1:0] rq_bank;
    logic [ROW_W-1:0] rq_row;
    logic [COL_W-1:0] rq_col;
    logic s1v;
    logic [DQ_W-1:0] s1d;
    logic [NBYTE-1:0] mq;
    logic [DQ_W-1:0] dq_o;
    logic [NBYTE-1:0] oe_n;
  } st_s;

  localparam st_s ST_RST = '{oe_n: '1, default: '0};

  st_s s_r;
  st_s s_nxt;
  cmd_e cmd;
  logic [BANK_W-1:0] ba;
  logic susp;
  logic live;
  logic push;
  logic [WR_W-1:0] push_word;
  logic [WR_W-1:0] buf_word;
  logic [LEFT_W-1:0] len;
  logic [NBANK-1:0] close_now;
  logic [NBANK-1:0] close_twr;

  assign cmd = cmd_e'({ras_n, cas_n, we_n});
  assign ba = {bank_select_high, bank_select_low};
  // an edge that saw the clock gate low freezes the next edge of a burst
  assign susp = !s_r.cke_q && s_r.act && !s_r.pd;
  assign live = !s_r.pd && !susp;

  always_comb begin
    if (burst_len_code == BL_FULL) begin
      len = FULL_PAGE_LEN;
    end else if (burst_len_code > BL_MAX_FIXED) begin
      len = LEFT_W'(1);
    end else begin
      len = LEFT_W'(1) << burst_len_code;
    end
  end

  always_comb begin
    s_nxt = s_r;
    push = 1'b0;
    push_word = {s_r.bank, s_r.row[s_r.bank], s_r.col, dqm, dq_in};
    close_now = '0;
    close_twr = '0;
    s_nxt.cke_q = cke;
    if (s_r.pd) begin
      // only the clock gate, with command inhibit or NOP, is watched while powered down
      if (cke && (cs_n || cmd == CMD_NOP)) begin
        s_nxt.pd = 1'b0;
        s_nxt.apd = 1'b0;
      end
    end else if (!susp) begin
      for (int b = 0; b < NBANK; b++) begin
        if (s_r.apc[b] != '0) begin
          s_nxt.apc[b] = s_r.apc[b] - APC_W'(1);
          close_now[b] = (s_r.apc[b] == APC_W'(1));
        end
      end
      // read data: array answers in the same cycle as the request
      s_nxt.s1v = s_r.rq;
      s_nxt.s1d = arr_rdata;
      s_nxt.dq_o = cas_lat3 ? s_r.s1d : arr_rdata;
      // byte mask reaches the outputs one edge after it is sampled
      s_nxt.oe_n = (cas_lat3 ? s_r.s1v : s_r.rq) ? s_r.mq : '1;
      s_nxt.mq = dqm;
      s_nxt.rq = 1'b0;
      if (s_r.act) begin
        if (s_r.wr) begin
          push = ~&dqm;
        end else begin
          s_nxt.rq = 1'b1;
          s_nxt.rq_bank = s_r.bank;
          s_nxt.rq_row = s_r.row[s_r.bank];
          s_nxt.rq_col = s_r.col;
        end
        // the wrap mask keeps the address inside its burst, a page wraps to 0
        s_nxt.col = (s_r.col & ~s_r.wrap) | ((s_r.col + COL_W'(1)) & s_r.wrap);
        s_nxt.left = s_r.left - LEFT_W'(1);
        if (s_r.left == LEFT_W'(1) && !s_r.full) begin
          s_nxt.act = 1'b0;
          if (s_r.ap) begin
            close_twr[s_r.bank] = s_r.wr;
            close_now[s_r.bank] = close_now[s_r.bank] | !s_r.wr;
          end
        end
      end
      if (!cs_n) begin
        case (cmd)
          CMD_ACTIVE: begin
            if (!s_r.open[ba]) begin
              s_nxt.open[ba] = 1'b1;
              s_nxt.row[ba] = addr;
            end
          end
          CMD_READ, CMD_WRITE: begin
            // an access to an idle bank is dropped
            if (s_r.open[ba]) begin
              if (s_r.act && s_r.ap && s_r.bank != ba) begin
                // read with auto precharge closes now; a write waits out recovery
                close_now[s_r.bank] = !s_r.wr;
                close_twr[s_r.bank] = s_r.wr;
              end
              s_nxt.wr = (cmd == CMD_WRITE);
              s_nxt.bank = ba;
              s_nxt.ap = addr[ALL_BANK_BIT];
              s_nxt.full = (burst_len_code == BL_FULL);
              s_nxt.wrap = COL_W'(len - LEFT_W'(1));
              s_nxt.left = len - LEFT_W'(1);
              s_nxt.act = (len != LEFT_W'(1));
              if (cmd == CMD_WRITE) begin
                // data beside the new command belongs to the new burst
                push = ~&dqm;
                push_word = {ba, s_r.row[ba], addr[COL_W-1:0], dqm, dq_in};
                s_nxt.s1v = 1'b0;
                s_nxt.oe_n = '1;
                if (write_single_mode_bit) begin
                  s_nxt.act = 1'b0;
                end
              end else begin
                push = 1'b0;
                s_nxt.rq = 1'b1;
                s_nxt.rq_bank = ba;
                s_nxt.rq_row = s_r.row[ba];
                s_nxt.rq_col = addr[COL_W-1:0];
              end
              s_nxt.col = (addr[COL_W-1:0] & ~s_nxt.wrap) |
                          ((addr[COL_W-1:0] + COL_W'(1)) & s_nxt.wrap);
              if (!s_nxt.act && addr[ALL_BANK_BIT]) begin
                close_twr[ba] = (cmd == CMD_WRITE);
                close_now[ba] = close_now[ba] | (cmd == CMD_READ);
              end
            end
          end
          CMD_PRECHARGE: begin
            if (addr[ALL_BANK_BIT]) begin
              close_now = '1;
            end else begin
              close_now[ba] = 1'b1;
            end
            if (s_r.act && (addr[ALL_BANK_BIT] || s_r.bank == ba)) begin
              s_nxt.act = 1'b0;
              s_nxt.rq = 1'b0;
              push = 1'b0;
            end
          end
          CMD_TERMINATE: begin
            if (s_r.act) begin
              s_nxt.act = 1'b0;
              s_nxt.rq = 1'b0;
              push = 1'b0;
            end
          end
          CMD_NOP: begin
            if (!cke && !s_r.act) begin
              s_nxt.pd = 1'b1;
              s_nxt.apd = |s_r.open;
            end
          end
          default: begin
          end
        endcase
      end else if (!cke && !s_r.act) begin
        s_nxt.pd = 1'b1;
        s_nxt.apd = |s_r.open;
      end
      for (int b = 0; b < NBANK; b++) begin
        if (close_now[b]) begin
          s_nxt.open[b] = 1'b0;
          s_nxt.apc[b] = '0;
        end else if (close_twr[b]) begin
          s_nxt.apc[b] = TWR_CYC;
        end
      end
    end
    s_nxt.sus = !cke && s_nxt.act && !s_nxt.pd;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // a stalled array is absorbed by two entries; wr_buf_ready low warns the controller
  skid_buffer2 #(.WIDTH(WR_W)) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push && live),
    .in_ready(wr_buf_ready),
    .in_data(push_word),
    .out_valid(arr_wr_valid),
    .out_ready(arr_wr_ready),
    .out_data(buf_word)
  );

  assign {arr_wr_bank, arr_wr_row, arr_wr_col, arr_wr_mask, arr_wr_data} = buf_word;
  assign arr_rd_valid = s_r.rq;
  assign arr_rd_bank = s_r.rq_bank;
  assign arr_rd_row = s_r.rq_row;
  assign arr_rd_col = s_r.rq_col;
  assign dq_out = s_r.dq_o;
  assign dq_oe_n = s_r.oe_n;
  assign power_down = s_r.pd;
  assign active_power_down = s_r.apd;
  assign clock_suspended = s_r.sus;
  assign bank_open = s_r.open;

  a_wr_first_word: assert property (@(posedge clk) disable iff (!rst_n)
    (live && !cs_n && cmd == CMD_WRITE && s_r.open[ba] && !(&dqm))
      |-> (push && push_word[NBYTE+DQ_W +: COL_W] == addr[COL_W-1:0]))
    else $error("write data not taken on command edge");
  a_wr_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_r.act && (cs_n || cmd != CMD_WRITE)) |-> !push)
    else $error("data taken with no write burst running");
  a_page_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (live && s_r.act && s_r.full && s_r.col == '1 && (cs_n || cmd == CMD_NOP))
      |=> (s_r.col == '0))
    else $error("full page burst did not wrap to column zero");
  a_rd_stops_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (live && !cs_n && cmd == CMD_READ && s_r.open[ba]) |-> !push ##1 !s_r.wr)
    else $error("write continued after read");
  a_term_drops: assert property (@(posedge clk) disable iff (!rst_n)
    (live && !cs_n && cmd == CMD_TERMINATE && s_r.act) |-> !push ##1 !s_r.act)
    else $error("terminate data was written");
  a_pd_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (live && !cke && (cs_n || cmd == CMD_NOP) && !s_r.act)
      |=> (s_r.pd && s_r.apd == |$past(s_r.open)))
    else $error("power-down not entered");
  a_pd_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.pd && cke && (cs_n || cmd == CMD_NOP)) |=> !s_r.pd)
    else $error("power-down not left");
  a_susp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    susp |=> ($stable(s_r.col) && $stable(s_r.left) && $stable(dq_out) && $stable(dq_oe_n)))
    else $error("burst moved on a suspended edge");
  a_single_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (live && !cs_n && cmd == CMD_WRITE && s_r.open[ba] && write_single_mode_bit)
      |=> !s_r.act)
    else $error("write burst longer than one in single mode");
  a_ap_interrupt: assert property (@(posedge clk) disable iff (!rst_n)
    (live && s_r.act && s_r.ap && !s_r.wr && !cs_n && cmd == CMD_READ
      && s_r.open[ba] && ba != s_r.bank) |=> !s_r.open[$past(s_r.bank)])
    else $error("interrupted bank not closed");
endmodule
`default_nettype wire

//--- sdram_pkg.sv
// shared widths, command codes and timing counts for the sdram device core
// assumes a single 100 MHz clock shared with the memory controller
package sdram_pkg;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DQ_W = 32;
  localparam int NBYTE = 4;
  localparam int NBANK = 4;
  localparam int BANK_W = 2;
  localparam int LEFT_W = COL_W + 1;
  localparam int APC_W = 4;
  localparam int WR_W = BANK_W + ROW_W + COL_W + NBYTE + DQ_W;
  // address bit that selects all banks on a precharge, and auto precharge on access
  localparam int ALL_BANK_BIT = 10;
  // burst length code that means a full page
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] BL_MAX_FIXED = 3'h3;
  localparam logic [LEFT_W-1:0] FULL_PAGE_LEN = 9'h100;
  // write recovery: one clock plus a fixed time
  localparam int CLK_NS = 10;
  localparam int TWR_EXTRA_NS = 7;
  localparam int TWR_CYC_I = 1 + (TWR_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [APC_W-1:0] TWR_CYC = APC_W'(TWR_CYC_I);
  // command code {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVE = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_TERMINATE = 3'b110,
    CMD_NOP = 3'b111
  } cmd_e;
endpackage

//--- skid_buffer2.sv
// two-entry buffer with valid and ready on both sides
// assumes producer and consumer on the same clock; outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module skid_buffer2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic v0;
    logic v1;
    logic rdy;
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
  } buf_s;

  buf_s s_r;
  buf_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.v0 && out_ready) begin
      s_nxt.v0 = s_r.v1;
      s_nxt.d0 = s_r.d1;
      s_nxt.v1 = 1'b0;
    end
    if (in_valid && s_r.rdy) begin
      if (!s_nxt.v0) begin
        s_nxt.v0 = 1'b1;
        s_nxt.d0 = in_data;
      end else begin
        s_nxt.v1 = 1'b1;
        s_nxt.d1 = in_data;
      end
    end
    // ready is registered so the filling side sees no combinational path
    s_nxt.rdy = !s_nxt.v1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{rdy: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = s_r.rdy;
  assign out_valid = s_r.v0;
  assign out_data = s_r.d0;
endmodule
`default_nettype wire

//--- cell_array_model.sv
// behavioural cell array behind the sdram core: write sink and read source
// assumes one clock; row is ignored, so the bench keeps a single row per bank
`timescale 1ns/1ps
`default_nettype none
module cell_array_model
  import sdram_pkg::*;
(
  // clock and stall control
  input wire logic clk,
  input wire logic hold,
  // write stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [BANK_W-1:0] wr_bank,
  input wire logic [COL_W-1:0] wr_col,
  input wire logic [NBYTE-1:0] wr_mask,
  input wire logic [DQ_W-1:0] wr_data,
  // read port
  input wire logic rd_valid,
  input wire logic [BANK_W-1:0] rd_bank,
  input wire logic [COL_W-1:0] rd_col,
  output logic [DQ_W-1:0] rdata
);
  logic [DQ_W-1:0] mem [NBANK*256];
  logic [DQ_W-1:0] last_r;
  initial begin
    foreach (mem[i]) mem[i] = '0;
    last_r = '0;
  end
  assign wr_ready = !hold;
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      for (int b = 0; b < NBYTE; b++) begin
        if (!wr_mask[b]) mem[{wr_bank, wr_col}][8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
    if (rd_valid) last_r <= rdata;
  end
  // outside a request the port shows the inverse of the last word, never a stale copy
  assign rdata = rd_valid ? mem[{rd_bank, rd_col}] : ~last_r;
endmodule
`default_nettype wire

//--- sdram_write_precharge_power_ops_tb.sv
// self-checking bench for sdram_core acting as the memory controller
// assumes a single row per bank and read-back with burst length one at CAS latency 2 or 3
`timescale 1ns/1ps
`default_nettype none
module sdram_write_precharge_power_ops_tb;
  import sdram_pkg::*;
  logic clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low;
  logic [ROW_W-1:0] addr;
  logic [NBYTE-1:0] dqm, dq_oe_n, arr_wr_mask;
  logic [DQ_W-1:0] dq_in, dq_out, arr_wr_data, arr_rdata;
  logic write_single_mode_bit, cas_lat3, arr_wr_valid, arr_wr_ready, wr_buf_ready;
  logic arr_rd_valid, power_down, active_power_down, clock_suspended, stall, gate, mask_on;
  logic [2:0] burst_len_code;
  logic [BANK_W-1:0] arr_wr_bank, arr_rd_bank;
  logic [ROW_W-1:0] arr_wr_row, arr_rd_row;
  logic [COL_W-1:0] arr_wr_col, arr_rd_col;
  logic [NBANK-1:0] bank_open;
  logic [DQ_W-1:0] exp_mem [NBANK][256];
  logic [DQ_W-1:0] old;
  int error_cnt, num_checks, cyc;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

  sdram_core i_dut (.clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
    .bank_select_high, .bank_select_low, .dqm, .dq_in, .dq_out, .dq_oe_n,
    .write_single_mode_bit, .burst_len_code, .cas_lat3, .arr_wr_valid, .arr_wr_ready,
    .arr_wr_bank, .arr_wr_row, .arr_wr_col, .arr_wr_mask, .arr_wr_data, .wr_buf_ready,
    .arr_rd_valid, .arr_rd_bank, .arr_rd_row, .arr_rd_col, .arr_rdata, .power_down,
    .active_power_down, .clock_suspended, .bank_open);

  cell_array_model i_array (.clk(clk), .hold(stall), .wr_valid(arr_wr_valid),
    .wr_ready(arr_wr_ready), .wr_bank(arr_wr_bank), .wr_col(arr_wr_col),
    .wr_mask(arr_wr_mask), .wr_data(arr_wr_data), .rd_valid(arr_rd_valid),
    .rd_bank(arr_rd_bank), .rd_col(arr_rd_col), .rdata(arr_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask

  function automatic logic [7:0] col_at(logic [7:0] c, int i, int bl);
    return 8'((int'(c) & ~(bl - 1)) | ((int'(c) + i) & (bl - 1)));
  endfunction

  function automatic int blen(logic [2:0] code, logic ws);
    if (ws) return 1;
    if (code == 3'h7) return 256;
    return (code <= 3'h3) ? (1 << code) : 1;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] m);
    for (int b = 0; b < 4; b++) if (!m[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction

  task automatic drive(cmd_e c, logic [1:0] b, logic [10:0] a, logic [31:0] d, logic [3:0] m);
    @(posedge clk);
    cke <= gate;
    {ras_n, cas_n, we_n} <= c;
    {bank_select_high, bank_select_low} <= b;
    addr <= a;
    dq_in <= d;
    dqm <= m;
  endtask

  task automatic nop();
    drive(CMD_NOP, 2'h0, 11'h0, $urandom, 4'h0);
  endtask

  task automatic open_all();
    for (int b = 0; b < 4; b++) drive(CMD_ACTIVE, 2'(b), 11'h0, $urandom, 4'h0);
    nop();
    #1 check("banks open", bank_open, 4'hF);
  endtask

  // bench reference memory follows every word the controller expects to land
  task automatic wr(logic [1:0] b, logic [7:0] c, logic [2:0] code, int n, logic ws);
    int bl;
    logic [31:0] d;
    logic [3:0] m;
    bl = blen(code, ws);
    burst_len_code <= code;
    write_single_mode_bit <= ws;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      m = (mask_on && $urandom_range(3) == 0) ? 4'($urandom) : 4'h0;
      drive(i == 0 ? CMD_WRITE : CMD_NOP, b, {3'h0, c}, d, m);
      if (i < bl) exp_mem[b][col_at(c, i, bl)] = merge(exp_mem[b][col_at(c, i, bl)], d, m);
    end
  endtask

  task automatic term();
    drive(CMD_TERMINATE, 2'h0, 11'h0, $urandom, 4'h0);
  endtask

  task automatic rd_chk(logic [1:0] b, logic [7:0] c, int cnt);
    repeat (4) nop();
    burst_len_code <= 3'h0;
    for (int i = 0; i < cnt; i++) begin
      drive(CMD_READ, b, {3'h0, 8'(c + i)}, $urandom, 4'h0);
      nop();
      nop();
      // one more edge before the word stands at the pins with the longer latency
      if (cas_lat3) nop();
      #1 check("read data", dq_out, exp_mem[b][8'(c + i)]);
      check("read enable", dq_oe_n, 4'h0);
    end
  endtask

  initial begin
    {rst_n, cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low} = 7'h3E;
    {addr, dqm, dq_in, write_single_mode_bit, cas_lat3, burst_len_code, stall} = '0;
    {cke, gate, mask_on} = 3'h7;
    foreach (exp_mem[b, c]) exp_mem[b][c] = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cs_n <= 1'b0;
    void'($urandom(32'h5474));
    #1 check("reset oe", dq_oe_n, 4'hF);
    check("reset buffer ready", wr_buf_ready, 1'b1);
    open_all();
    wr(1, 8'd64, 3'h1, 4, 0);
    rd_chk(1, 8'd64, 4);
    wr(0, 8'd32, 3'h2, 2, 0);
    drive(CMD_READ, 2'h0, 11'd32, $urandom, 4'h0);
    rd_chk(0, 8'd32, 4);
    wr(0, 8'd40, 3'h2, 2, 0);
    wr(0, 8'd48, 3'h2, 4, 0);
    term();
    rd_chk(0, 8'd40, 12);
    wr(2, 8'd254, 3'h7, 4, 0);
    term();
    rd_chk(2, 8'd254, 4);
    wr(3, 8'd60, 3'h3, 3, 1);
    term();
    rd_chk(3, 8'd56, 8);
    burst_len_code <= 3'h2;
    write_single_mode_bit <= 1'b0;
    exp_mem[1][8] = $urandom;
    exp_mem[1][9] = $urandom;
    drive(CMD_WRITE, 2'h1, 11'd8, exp_mem[1][8], 4'h0);
    gate = 1'b0;
    drive(CMD_NOP, 2'h0, 11'h0, exp_mem[1][9], 4'h0);
    gate = 1'b1;
    drive(CMD_WRITE, 2'h1, 11'd9, $urandom, 4'h0);
    #1 check("suspended", clock_suspended, 1'b1);
    exp_mem[1][10] = $urandom;
    exp_mem[1][11] = $urandom;
    drive(CMD_NOP, 2'h0, 11'h0, exp_mem[1][10], 4'h0);
    drive(CMD_NOP, 2'h0, 11'h0, exp_mem[1][11], 4'h0);
    rd_chk(1, 8'd8, 4);
    mask_on = 1'b0;
    stall = 1'b1;
    wr(3, 8'd200, 3'h1, 2, 0);
    nop();
    nop();
    #1 check("buffer full", {wr_buf_ready, arr_wr_valid}, 2'b01);
    stall = 1'b0;
    rd_chk(3, 8'd200, 2);
    check("buffer empty", arr_wr_valid, 1'b0);
    mask_on = 1'b1;
    gate = 1'b0;
    nop();
    nop();
    #1 check("active power-down", {power_down, active_power_down}, 2'b11);
    drive(CMD_WRITE, 2'h0, 11'd100, $urandom, 4'h0);
    gate = 1'b1;
    nop();
    nop();
    #1 check("power-down left", power_down, 1'b0);
    drive(CMD_PRECHARGE, 2'h2, 11'h0, $urandom, 4'h0);
    nop();
    #1 check("one bank closed", bank_open, 4'hB);
    drive(CMD_PRECHARGE, 2'h1, 11'h400, $urandom, 4'h0);
    nop();
    #1 check("all closed", bank_open, 4'h0);
    // enter through command inhibit this time
    cs_n <= 1'b1;
    gate = 1'b0;
    nop();
    nop();
    #1 check("idle power-down", {power_down, active_power_down}, 2'b10);
    cs_n <= 1'b0;
    gate = 1'b1;
    nop();
    old = exp_mem[0][120];
    wr(0, 8'd120, 3'h0, 1, 0);
    exp_mem[0][120] = old;
    repeat (3) nop();
    open_all();
    rd_chk(0, 8'd100, 21);
    burst_len_code <= 3'h2;
    drive(CMD_READ, 2'h0, 11'h400, $urandom, 4'h0);
    drive(CMD_READ, 2'h1, 11'h0, $urandom, 4'h0);
    nop();
    #1 check("read interrupt close", bank_open, 4'hE);
    drive(CMD_READ, 2'h2, 11'h400, $urandom, 4'h0);
    // burst code kept at 2 (four words) so the read above still runs; single write keeps bank 3 tidy
    wr(3, 8'd0, 3'h2, 1, 1);
    nop();
    #1 check("write interrupt close", bank_open, 4'hA);
    open_all();
    for (int k = 0; k < 8; k++) begin
      logic [1:0] b;
      logic [7:0] c;
      b = 2'($urandom_range(3));
      c = 8'($urandom);
      cas_lat3 <= k[0];
      wr(b, c, codes[$urandom_range(4)], $urandom_range(9, 1), $urandom_range(3) == 0);
      term();
      rd_chk(b, c & 8'hF8, 16);
    end
    // a precharge cuts a full page write; the edge before it and its own are masked
    wr(1, 8'd16, 3'h7, 3, 0);
    drive(CMD_NOP, 2'h1, 11'h0, $urandom, 4'hF);
    drive(CMD_PRECHARGE, 2'h1, 11'h0, $urandom, 4'hF);
    nop();
    #1 check("precharge cut", bank_open, 4'hD);
    repeat (3) nop();
    open_all();
    rd_chk(1, 8'd16, 8);
    stop_test();
  end
endmodule
`default_nettype wire
